/* cfgp_config_data_port.sv */
`timescale 1ns/1ps
`include "cfgp_params.svh"

// Contract
// - Selected only when select_low_n low, select_high high; sync peripheral ignores both, express uses select_high only
// - Write strobe low captures data bus byte
// - Read strobe drives D7 ready, others high
// - Both strobes low: write wins, read ignored
// - Express: select_high enables data acceptance
// - Master parallel drives 18-bit PROM address
// - Larger variants add 4 high address bits
// - Parallel and peripheral take bytes on bus
// - Serial modes sample input on clock rise
// - Parallel modes: serial input is bit D0
// - Non-express modes forward serial data out
// - Output changes on fall, 1.5 periods later
// - Express: serial out enables downstream device
// - Signal ready; host writes only when ready
// - Drive clock in master, async peripheral modes
// - Sample mode pins after init goes high
module cfgp_config_data_port #(
    parameter int EXT_ADDR_BITS = `CFGP_EXT_ADDR_BITS,
    parameter bit EXT_ADDR_EN = 1'b0,
    parameter int FIFO_DEPTH = `CFGP_FIFO_DEPTH,
    parameter int CONFIG_CLOCK_HALF = `CFGP_CONFIG_CLOCK_HALF_CYC
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic PROGRAM_N,
    input wire logic INIT_N,
    input wire logic [2:0] MODE_SELECT_PINS,
    input wire logic SELECT_LOW_N,
    input wire logic SELECT_HIGH,
    input wire logic WRITE_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic [7:0] CONFIG_DATA_BUS_I,
    output logic [7:0] CONFIG_DATA_BUS_O,
    output logic [7:0] CONFIG_DATA_BUS_OE,
    input wire logic CONFIG_CLOCK_I,
    output logic CONFIG_CLOCK_O,
    output logic CONFIG_CLOCK_OE,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OUT_OE,
    output logic [`CFGP_BASE_ADDR_BITS+EXT_ADDR_BITS-1:0] PROM_ADDRESS,
    output logic [`CFGP_BASE_ADDR_BITS+EXT_ADDR_BITS-1:0] PROM_ADDRESS_OE,
    output logic READY_BUSY_OUT,
    output logic READY_BUSY_OUT_OE,
    input wire logic CONFIG_DONE,
    input wire logic CHAIN_PASS,
    output logic [7:0] CFG_BYTE,
    output logic CFG_VALID,
    input wire logic CFG_READY,
    output logic LOADING
);
    localparam int AW = `CFGP_BASE_ADDR_BITS + EXT_ADDR_BITS;

    initial
    begin
        if (EXT_ADDR_BITS < 0 || EXT_ADDR_BITS > 4 || CONFIG_CLOCK_HALF < 1 || CONFIG_CLOCK_HALF > 65535)
        begin
            $error("cfgp_config_data_port: unsupported parameter values");
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [`CFGP_SYNC_BITS-1:0] pins_s;
    logic s_prog_n;
    logic s_init_n;
    logic [2:0] s_mode;
    logic s_cs_low_n;
    logic s_cs_high;
    logic s_ws_n;
    logic s_rs_n;
    logic [7:0] s_bus;
    logic s_config_clock;

    cfgp_sync #(
        .W(`CFGP_SYNC_BITS),
        .RST_VAL('1)
    ) u_sync (
        .CLOCK(CLOCK),
        .NRST(NRST),
        .d({PROGRAM_N, INIT_N, MODE_SELECT_PINS, SELECT_LOW_N, SELECT_HIGH,
            WRITE_STROBE_N, READ_STROBE_N, CONFIG_DATA_BUS_I, CONFIG_CLOCK_I}),
        .q(pins_s)
    );

    assign {s_prog_n, s_init_n, s_mode, s_cs_low_n, s_cs_high, s_ws_n, s_rs_n,
            s_bus, s_config_clock} = pins_s;

    // ----------------------------------------
    // State
    // ----------------------------------------
    cfgp_pkg::cfgp_state_t state, next_state;
    cfgp_pkg::cfgp_mode_t mode, next_mode;
    logic config_clock_o, next_config_clock_o;
    logic [15:0] div_cnt, next_div_cnt;
    logic prev_config_clock, next_prev_config_clock;
    logic prev_ws_n, next_prev_ws_n;
    logic [7:0] shift, next_shift;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic stage_a, next_stage_a;
    logic stage_b, next_stage_b;
    logic dout, next_dout;
    logic addr_step, next_addr_step;
    logic [AW-1:0] addr, next_addr;
    logic [7:0] hold_byte, next_hold_byte;
    logic hold_full, next_hold_full;
    logic [7:0] bus_o, next_bus_o;
    logic [7:0] bus_oe, next_bus_oe;
    logic rdy, next_rdy;

    logic fifo_in_ready;
    logic loading;
    logic master;
    logic config_clock_lvl;
    logic rise;
    logic fall;
    logic selected;
    logic ws_fall;
    logic serial_in;
    logic push;
    cfgp_pkg::cfgp_mode_t pin_mode;

    assign loading = (state == cfgp_pkg::ST_LOAD);
    assign master = (mode == cfgp_pkg::MODE_MASTER_SERIAL)
                 || (mode == cfgp_pkg::MODE_MASTER_PAR)
                 || (mode == cfgp_pkg::MODE_ASYNC_PERIPH);
    assign config_clock_lvl = master ? config_clock_o : s_config_clock;
    assign rise = loading && config_clock_lvl && !prev_config_clock;
    assign fall = loading && !config_clock_lvl && prev_config_clock;
    assign selected = !s_cs_low_n && s_cs_high;
    assign ws_fall = prev_ws_n && !s_ws_n;
    // The serial input pin doubles as bit 0 of the parallel bus
    assign serial_in = s_bus[0];
    assign push = hold_full && fifo_in_ready;

    always_comb
    begin
        unique case (s_mode)
            `CFGP_M_MASTER_SERIAL: pin_mode = cfgp_pkg::MODE_MASTER_SERIAL;
            `CFGP_M_SLAVE_SERIAL: pin_mode = cfgp_pkg::MODE_SLAVE_SERIAL;
            `CFGP_M_MASTER_PAR: pin_mode = cfgp_pkg::MODE_MASTER_PAR;
            `CFGP_M_SYNC_PERIPH: pin_mode = cfgp_pkg::MODE_SYNC_PERIPH;
            `CFGP_M_ASYNC_PERIPH: pin_mode = cfgp_pkg::MODE_ASYNC_PERIPH;
            `CFGP_M_EXPRESS: pin_mode = cfgp_pkg::MODE_EXPRESS;
            default: pin_mode = cfgp_pkg::MODE_SLAVE_SERIAL;
        endcase
    end

    always_comb
    begin
        next_state = state;
        next_mode = mode;
        next_config_clock_o = config_clock_o;
        next_div_cnt = div_cnt;
        next_prev_config_clock = config_clock_lvl;
        next_prev_ws_n = s_ws_n;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_stage_a = stage_a;
        next_stage_b = stage_b;
        next_dout = dout;
        next_addr_step = addr_step;
        next_addr = addr;
        next_hold_byte = hold_byte;
        next_hold_full = hold_full;
        next_bus_o = 8'h00;
        next_bus_oe = 8'h00;
        next_rdy = 1'b0;

        // ----------------------------------------
        // Sequencing
        // ----------------------------------------
        unique case (state)
            cfgp_pkg::ST_CLEAR:
            begin
                if (s_prog_n)
                begin
                    next_state = cfgp_pkg::ST_WAIT_INIT;
                end
            end
            cfgp_pkg::ST_WAIT_INIT:
            begin
                if (s_init_n)
                begin
                    next_mode = pin_mode;
                    next_state = cfgp_pkg::ST_LOAD;
                end
            end
            cfgp_pkg::ST_LOAD:
            begin
                if (CONFIG_DONE)
                begin
                    next_state = cfgp_pkg::ST_RELEASED;
                end
            end
            cfgp_pkg::ST_RELEASED:
            begin
                next_state = cfgp_pkg::ST_RELEASED;
            end
        endcase

        // ----------------------------------------
        // Driven configuration clock
        // ----------------------------------------
        // Hold the clock low while a byte waits, so the source stalls
        if (loading && master && !(hold_full && !config_clock_o))
        begin
            if (div_cnt == 16'(CONFIG_CLOCK_HALF - 1))
            begin
                next_div_cnt = 16'h0000;
                next_config_clock_o = !config_clock_o;
            end
            else
            begin
                next_div_cnt = div_cnt + 16'h0001;
            end
        end

        // ----------------------------------------
        // Byte capture
        // ----------------------------------------
        if (push)
        begin
            next_hold_full = 1'b0;
        end
        unique case (mode)
            cfgp_pkg::MODE_MASTER_SERIAL, cfgp_pkg::MODE_SLAVE_SERIAL:
            begin
                if (rise)
                begin
                    // First bit of a byte lands in bit 0
                    next_shift = {serial_in, shift[7:1]};
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7 && !hold_full)
                    begin
                        next_hold_byte = {serial_in, shift[7:1]};
                        next_hold_full = 1'b1;
                    end
                end
            end
            cfgp_pkg::MODE_MASTER_PAR:
            begin
                if (rise)
                begin
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7 && !hold_full)
                    begin
                        next_hold_byte = s_bus;
                        next_hold_full = 1'b1;
                        next_addr_step = 1'b1;
                    end
                end
                if (fall && addr_step)
                begin
                    next_addr_step = 1'b0;
                    next_addr = addr + AW'(1);
                end
            end
            cfgp_pkg::MODE_ASYNC_PERIPH:
            begin
                if (loading && selected && ws_fall && !hold_full)
                begin
                    next_hold_byte = s_bus;
                    next_hold_full = 1'b1;
                end
                // A write strobe in the same cycle suppresses the status read
                if (loading && selected && !s_rs_n && s_ws_n)
                begin
                    next_bus_o = {!hold_full, `CFGP_STATUS_FILL};
                    next_bus_oe = 8'hFF;
                end
            end
            cfgp_pkg::MODE_SYNC_PERIPH:
            begin
                if (rise && !hold_full)
                begin
                    next_hold_byte = s_bus;
                    next_hold_full = 1'b1;
                end
            end
            cfgp_pkg::MODE_EXPRESS:
            begin
                if (rise && s_cs_high && !hold_full)
                begin
                    next_hold_byte = s_bus;
                    next_hold_full = 1'b1;
                end
            end
        endcase
        if (mode == cfgp_pkg::MODE_ASYNC_PERIPH || mode == cfgp_pkg::MODE_SYNC_PERIPH)
        begin
            next_rdy = !next_hold_full;
        end

        // ----------------------------------------
        // Serial forwarding
        // ----------------------------------------
        if (mode == cfgp_pkg::MODE_EXPRESS)
        begin
            next_dout = CHAIN_PASS;
        end
        else
        begin
            if (rise)
            begin
                next_stage_a = serial_in;
                next_stage_b = stage_a;
            end
            if (fall)
            begin
                next_dout = stage_b;
            end
        end

        // A restart clears the sequencer, counters, address and hold slot; the FIFO keeps its bytes
        if (!s_prog_n)
        begin
            next_state = cfgp_pkg::ST_CLEAR;
            next_config_clock_o = 1'b0;
            next_div_cnt = 16'h0000;
            next_bit_cnt = 3'h0;
            next_addr = AW'(`CFGP_RESET_ADDR);
            next_addr_step = 1'b0;
            next_hold_full = 1'b0;
            next_dout = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            state <= cfgp_pkg::ST_CLEAR;
            mode <= cfgp_pkg::MODE_SLAVE_SERIAL;
            config_clock_o <= 1'b0;
            div_cnt <= 16'h0000;
            prev_config_clock <= 1'b1;
            prev_ws_n <= 1'b1;
            shift <= 8'h00;
            bit_cnt <= 3'h0;
            stage_a <= 1'b0;
            stage_b <= 1'b0;
            dout <= 1'b0;
            addr_step <= 1'b0;
            addr <= AW'(`CFGP_RESET_ADDR);
            hold_byte <= 8'h00;
            hold_full <= 1'b0;
            bus_o <= 8'h00;
            bus_oe <= 8'h00;
            rdy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            mode <= next_mode;
            config_clock_o <= next_config_clock_o;
            div_cnt <= next_div_cnt;
            prev_config_clock <= next_prev_config_clock;
            prev_ws_n <= next_prev_ws_n;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            stage_a <= next_stage_a;
            stage_b <= next_stage_b;
            dout <= next_dout;
            addr_step <= next_addr_step;
            addr <= next_addr;
            hold_byte <= next_hold_byte;
            hold_full <= next_hold_full;
            bus_o <= next_bus_o;
            bus_oe <= next_bus_oe;
            rdy <= next_rdy;
        end
    end

    // ----------------------------------------
    // Byte buffer toward the configuration core
    // ----------------------------------------
    cfgp_fifo #(
        .WIDTH(`CFGP_BYTE_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .CLOCK(CLOCK),
        .NRST(NRST),
        .in_valid(hold_full),
        .in_ready(fifo_in_ready),
        .in_data(hold_byte),
        .out_valid(CFG_VALID),
        .out_ready(CFG_READY),
        .out_data(CFG_BYTE)
    );

    // ----------------------------------------
    // Pin drivers, all released outside loading
    // ----------------------------------------
    assign CONFIG_DATA_BUS_O = bus_o;
    assign CONFIG_DATA_BUS_OE = loading ? bus_oe : 8'h00;
    assign CONFIG_CLOCK_O = config_clock_o;
    assign CONFIG_CLOCK_OE = loading && master;
    assign SERIAL_DATA_OUT = dout;
    assign SERIAL_DATA_OUT_OE = loading;
    assign PROM_ADDRESS = addr;
    assign PROM_ADDRESS_OE = (loading && mode == cfgp_pkg::MODE_MASTER_PAR)
        ? {{EXT_ADDR_BITS{EXT_ADDR_EN}}, {`CFGP_BASE_ADDR_BITS{1'b1}}}
        : '0;
    assign READY_BUSY_OUT = rdy;
    assign READY_BUSY_OUT_OE = loading && (mode == cfgp_pkg::MODE_ASYNC_PERIPH
                                        || mode == cfgp_pkg::MODE_SYNC_PERIPH);
    assign LOADING = loading;
endmodule // cfgp_config_data_port

/* cfgp_config_data_port_asserts.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Pin-level checks
// ----------------------------------------
module cfgp_config_data_port_asserts (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [2:0] MODE_SELECT_PINS,
    input wire logic SELECT_LOW_N,
    input wire logic SELECT_HIGH,
    input wire logic WRITE_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic [7:0] CONFIG_DATA_BUS_O,
    input wire logic [7:0] CONFIG_DATA_BUS_OE,
    input wire logic CONFIG_CLOCK_OE,
    input wire logic SERIAL_DATA_OUT,
    input wire logic READY_BUSY_OUT,
    input wire logic READY_BUSY_OUT_OE,
    input wire logic CHAIN_PASS,
    input wire logic [7:0] CFG_BYTE,
    input wire logic CFG_VALID,
    input wire logic CFG_READY,
    input wire logic LOADING
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);

    logic sel;
    logic async_mode;
    assign sel = !SELECT_LOW_N && SELECT_HIGH;
    assign async_mode = LOADING && MODE_SELECT_PINS == 3'h5;

    // Pins pass two sync stages, so pin conditions are held a few cycles
    a_deselect_quiet: assert property ((!sel)[*5] |-> CONFIG_DATA_BUS_OE == 8'h00)
        else $error("status driven while deselected");
    a_status_drive: assert property ((async_mode && sel && !READ_STROBE_N && WRITE_STROBE_N)[*5]
        |-> CONFIG_DATA_BUS_OE == 8'hFF)
        else $error("status not driven");
    a_status_fill: assert property (CONFIG_DATA_BUS_OE != 8'h00
        |-> CONFIG_DATA_BUS_O[6:0] == 7'h7F)
        else $error("status low bits not high");
    a_write_wins: assert property ((!WRITE_STROBE_N && !READ_STROBE_N)[*5]
        |-> CONFIG_DATA_BUS_OE == 8'h00)
        else $error("read not overridden");
    a_busy_on_write: assert property (async_mode && sel && READY_BUSY_OUT && $fell(WRITE_STROBE_N)
        ##1 (sel && !WRITE_STROBE_N)[*3] |-> ##[0:3] !READY_BUSY_OUT)
        else $error("no busy after write");
    a_ready_back: assert property ($fell(READY_BUSY_OUT) && READY_BUSY_OUT_OE && !CFG_VALID
        |-> ##[1:3] READY_BUSY_OUT)
        else $error("ready not restored");
    a_fifo_hold: assert property (CFG_VALID && !CFG_READY
        |=> CFG_VALID && $stable(CFG_BYTE))
        else $error("stalled byte changed");
    a_clock_dir: assert property ((LOADING && $stable(MODE_SELECT_PINS))[*3]
        |-> CONFIG_CLOCK_OE == (MODE_SELECT_PINS inside {3'h0, 3'h4, 3'h5}))
        else $error("clock direction wrong");
    a_express_pass: assert property ((LOADING && MODE_SELECT_PINS == 3'h6 && $stable(CHAIN_PASS))[*4]
        |-> SERIAL_DATA_OUT == CHAIN_PASS)
        else $error("chain enable wrong");
    a_release_quiet: assert property ((!LOADING)[*2] |-> CONFIG_DATA_BUS_OE == 8'h00
        && !CONFIG_CLOCK_OE && !READY_BUSY_OUT_OE)
        else $error("pins driven outside load");

    c_busy: cover property (READY_BUSY_OUT_OE && !READY_BUSY_OUT);
    c_stall: cover property (CFG_VALID && !CFG_READY);
    c_status: cover property (CONFIG_DATA_BUS_OE == 8'hFF);
endmodule // cfgp_config_data_port_asserts

bind cfgp_config_data_port cfgp_config_data_port_asserts i_cfgp_config_data_port_asserts (.*);

/* cfgp_fifo.sv */
`timescale 1ns/1ps

module cfgp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic do_push;
    logic do_pop;

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
        begin
            $error("cfgp_fifo: DEPTH must be at least 2 and WIDTH at least 1");
        end
    end

    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (do_push)
        begin
            next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
        end
        if (do_pop)
        begin
            next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
        end
        if (do_push && !do_pop)
        begin
            next_count = count + CW'(1);
        end
        else if (do_pop && !do_push)
        begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage has no reset; out_valid guards every read
    always_ff @(posedge CLOCK)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // cfgp_fifo

/* cfgp_link_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Upstream serial source, forward monitor
// ----------------------------------------
module cfgp_link_model (
    output logic sclk,
    output logic sdin,
    input wire logic sdout,
    output int err
);
    // Clock stands low between frames; data rests at its pull-up level
    initial
    begin
        sclk = 1'b0;
        sdin = 1'b1;
        err = 0;
    end

    // Offset of 3 ns keeps link edges away from system clock edges
    task automatic pulse();
        #83 sclk = 1'b1;
        #80 sclk = 1'b0;
    endtask

    task automatic send(input logic [7:0] b);
        #3;
        for (int i = 0; i < 8; i++)
        begin
            #5 sdin = b[i];
            #73 if (i > 1 && sdout !== b[i-2]) err++;
            #2 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #78 if (sdout !== b[6]) err++;
        sdin = 1'b1;
    endtask
endmodule // cfgp_link_model

/* cfgp_params.svh */
`ifndef CFGP_PARAMS_SVH
`define CFGP_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CFGP_CLK_PERIOD_NS 20
// Shortest half period of the driven configuration clock in slow mode
`define CFGP_CONFIG_CLOCK_HALF_NS 400
`define CFGP_CONFIG_CLOCK_HALF_CYC \
    ((`CFGP_CONFIG_CLOCK_HALF_NS + `CFGP_CLK_PERIOD_NS - 1) / `CFGP_CLK_PERIOD_NS)

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define CFGP_BYTE_BITS 8
`define CFGP_BASE_ADDR_BITS 18
`define CFGP_EXT_ADDR_BITS 4
`define CFGP_FIFO_DEPTH 4
`define CFGP_SYNC_BITS 18

// ----------------------------------------
// Mode pin codes and fixed values
// ----------------------------------------
`define CFGP_M_MASTER_SERIAL 3'h0
`define CFGP_M_SLAVE_SERIAL 3'h7
`define CFGP_M_MASTER_PAR 3'h4
`define CFGP_M_SYNC_PERIPH 3'h3
`define CFGP_M_ASYNC_PERIPH 3'h5
`define CFGP_M_EXPRESS 3'h6
`define CFGP_STATUS_FILL 7'h7F
`define CFGP_RESET_ADDR 22'h000000

`endif

/* cfgp_pkg.sv */
package cfgp_pkg;

    typedef enum logic [1:0] {
        ST_CLEAR,
        ST_WAIT_INIT,
        ST_LOAD,
        ST_RELEASED
    } cfgp_state_t;

    typedef enum logic [2:0] {
        MODE_MASTER_SERIAL,
        MODE_SLAVE_SERIAL,
        MODE_MASTER_PAR,
        MODE_ASYNC_PERIPH,
        MODE_SYNC_PERIPH,
        MODE_EXPRESS
    } cfgp_mode_t;

endpackage

/* cfgp_sync.sv */
`timescale 1ns/1ps

module cfgp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    initial
    begin
        if (W < 1)
        begin
            $error("cfgp_sync: W must be at least 1");
        end
    end

    // Two stages; only the second is read by the block
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // cfgp_sync

/* test_cfgp_config_data_port.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Bench
// ----------------------------------------
module test_cfgp_config_data_port;
    logic CLOCK = 1'b0;
    logic NRST = 1'b0;
    logic PROGRAM_N = 1'b0;
    logic INIT_N = 1'b1;
    logic [2:0] MODE_SELECT_PINS = 3'h5;
    logic SELECT_LOW_N = 1'b1;
    logic SELECT_HIGH = 1'b0;
    logic WRITE_STROBE_N = 1'b1;
    logic READ_STROBE_N = 1'b1;
    logic CONFIG_DONE = 1'b0;
    logic CHAIN_PASS = 1'b0;
    logic CFG_READY = 1'b0;
    logic [7:0] host_bus = 8'hFF;
    logic [7:0] CONFIG_DATA_BUS_I, CONFIG_DATA_BUS_O, CONFIG_DATA_BUS_OE, CFG_BYTE;
    logic CONFIG_CLOCK_I, CONFIG_CLOCK_O, CONFIG_CLOCK_OE, SERIAL_DATA_OUT;
    logic SERIAL_DATA_OUT_OE, READY_BUSY_OUT, READY_BUSY_OUT_OE, CFG_VALID, LOADING, sdin;
    logic [21:0] PROM_ADDRESS, PROM_ADDRESS_OE;
    int n_fail = 0;
    int cmp_count = 0;
    int link_err;

    // Bit 0 of the bus is the serial input pin, shared with the link source
    assign CONFIG_DATA_BUS_I = {host_bus[7:1], host_bus[0] & sdin};

    always #10 CLOCK = ~CLOCK;

    cfgp_config_data_port #(.CONFIG_CLOCK_HALF(2)) i_cfgp_config_data_port (.*);
    cfgp_link_model i_cfgp_link_model (.sclk(CONFIG_CLOCK_I), .sdin(sdin),
        .sdout(SERIAL_DATA_OUT), .err(link_err));

    task chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    task start(input logic [2:0] m);
        @(posedge CLOCK);
        PROGRAM_N <= 1'b0;
        MODE_SELECT_PINS <= m;
        host_bus <= 8'hFF;
        cyc(5);
        PROGRAM_N <= 1'b1;
        cyc(8);
        chk(LOADING, "not loading");
    endtask

    task wr(input logic [7:0] d);
        @(posedge CLOCK);
        host_bus <= d;
        WRITE_STROBE_N <= 1'b0;
        cyc(4);
        WRITE_STROBE_N <= 1'b1;
        cyc(4);
    endtask

    task get(input logic [7:0] d);
        cyc(1);
        for (int i = 0; i < 40 && CFG_VALID !== 1'b1; i++) @(posedge CLOCK);
        chk(CFG_VALID === 1'b1 && CFG_BYTE === d, "wrong byte");
        CFG_READY <= 1'b1;
        @(posedge CLOCK);
        CFG_READY <= 1'b0;
    endtask

    task t_async();
        start(3'h5);
        SELECT_LOW_N <= 1'b0;
        SELECT_HIGH <= 1'b1;
        cyc(4);
        chk(READY_BUSY_OUT & READY_BUSY_OUT_OE, "not ready");
        wr(8'hA5);
        get(8'hA5);
        host_bus <= 8'h3C;
        WRITE_STROBE_N <= 1'b0;
        READ_STROBE_N <= 1'b0;
        cyc(6);
        chk(CONFIG_DATA_BUS_OE === 8'h00, "read won");
        WRITE_STROBE_N <= 1'b1;
        READ_STROBE_N <= 1'b1;
        get(8'h3C);
        READ_STROBE_N <= 1'b0;
        cyc(6);
        chk(CONFIG_DATA_BUS_OE === 8'hFF && CONFIG_DATA_BUS_O === 8'hFF, "status");
        READ_STROBE_N <= 1'b1;
        SELECT_HIGH <= 1'b0;
        wr(8'h11);
        cyc(10);
        chk(CFG_VALID === 1'b0, "deselected write");
        $display("async test done");
    endtask

    // FIFO and hold fill up with the core stalled, then drain in order
    task t_fill();
        SELECT_HIGH <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            for (int k = 0; k < 20 && READY_BUSY_OUT !== 1'b1; k++) @(posedge CLOCK);
            wr(8'(i + 64));
        end
        wr(8'hEE);
        cyc(10);
        chk(READY_BUSY_OUT === 1'b0, "ready while full");
        READ_STROBE_N <= 1'b0;
        cyc(6);
        chk(CONFIG_DATA_BUS_O === 8'h7F, "busy status");
        READ_STROBE_N <= 1'b1;
        for (int i = 0; i < 5; i++) get(8'(i + 64));
        cyc(10);
        chk(CFG_VALID === 1'b0 && READY_BUSY_OUT === 1'b1, "refused kept");
        $display("fill test done");
    endtask

    task t_serial();
        start(3'h7);
        i_cfgp_link_model.send(8'h3C);
        get(8'h3C);
        chk(link_err == 0, "forwarding");
        $display("serial test done");
    endtask

    task t_express();
        start(3'h6);
        SELECT_HIGH <= 1'b0;
        CHAIN_PASS <= 1'b1;
        cyc(6);
        chk(SERIAL_DATA_OUT === 1'b1, "chain high");
        CHAIN_PASS <= 1'b0;
        host_bus <= 8'h5A;
        cyc(6);
        chk(SERIAL_DATA_OUT === 1'b0, "chain low");
        i_cfgp_link_model.pulse();
        cyc(10);
        chk(CFG_VALID === 1'b0, "disabled byte");
        SELECT_HIGH <= 1'b1;
        i_cfgp_link_model.pulse();
        get(8'h5A);
        $display("express test done");
    endtask

    task t_modes();
        logic [2:0] codes [6] = '{3'h0, 3'h7, 3'h4, 3'h3, 3'h5, 3'h6};
        foreach (codes[i])
        begin
            start(codes[i]);
            chk(CONFIG_CLOCK_OE === (codes[i] inside {3'h0, 3'h4, 3'h5}), "clock");
            chk(PROM_ADDRESS_OE === (codes[i] == 3'h4 ? 22'h03FFFF : 22'h000000), "addr");
            chk(READY_BUSY_OUT_OE === (codes[i] inside {3'h3, 3'h5}), "ready");
            if (codes[i] == 3'h4)
            begin
                cyc(40);
                chk(PROM_ADDRESS === 22'h000001 && CONFIG_CLOCK_O === 1'b1, "addr");
            end
        end
        $display("mode test done");
    endtask

    task t_done();
        CONFIG_DONE <= 1'b1;
        cyc(4);
        chk(!LOADING && CONFIG_DATA_BUS_OE === 8'h00 && !SERIAL_DATA_OUT_OE, "release");
        $display("release test done");
    endtask

    task conclude();
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        cyc(4);
        NRST <= 1'b1;
        PROGRAM_N <= 1'b1;
        t_async();
        t_fill();
        t_serial();
        t_express();
        t_modes();
        t_done();
        conclude();
    end

    initial
    begin
        #400000;
        n_fail++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        conclude();
    end
endmodule // test_cfgp_config_data_port
